/* hw/lpms_sequencer.v */
/*
  Low power mode sequencer: picks sleep, clocked-off standby or deep
  standby when the core retires its sleep instruction, gates the chip
  clock, counts the settling period and reports the exit cause.
  Assumes one 50 MHz clock, synchronous inputs, and an APB master.
*/
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "lpms_defs.vh"

module lpms_sequencer #(
  parameter NPINS = 8,
  parameter DEEP_PIN_MASK = 8'hF0
)(
  // Clock and reset
  input wire I_REF_CLK,
  input wire I_RST,
  // APB slave
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [11:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  output reg [31:0] O_PRDATA,
  output reg O_PREADY,
  output reg O_PSLVERR,
  // Core side
  input wire I_SLEEP_RETIRE,
  input wire I_IRQ_ACCEPT,
  input wire I_BUS_ERROR,
  input wire [3:0] I_CPU_MASK_LEVEL,
  input wire [NPINS*4-1:0] I_PIN_PRIO,
  // Pins, synchronous, active low resets
  input wire I_NMI_PIN,
  input wire [NPINS-1:0] I_IRQ_PINS,
  input wire I_POR_N,
  input wire I_MANUAL_RESET_PIN_N,
  // Outputs to the chip
  output reg O_CPU_HALT,
  output reg O_CHIP_CLK_EN,
  output reg O_EXT_CLK_EN,
  output reg O_PERIPH_INIT,
  output reg O_POWER_OFF,
  output reg O_PIN_HOLD,
  output reg O_DMA_ABORT,
  output reg O_POR_HOLD,
  output reg O_MANUAL_RESET_PIN_HOLD,
  output reg [2:0] O_EXIT_CAUSE,
  output reg O_EXIT_PULSE
);

  // Committed control and configuration registers
  reg standby_r;
  reg deep_r;
  reg [1:0] clk_mode_r;
  reg [2:0] settle_sel_r;
  reg [2:0] deep_settle_sel_r;
  reg [15:0] flags_r;
  reg [15:0] flags_seen_r;
  reg [NPINS*2-1:0] pin_sense_r;
  reg nmi_edge_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg nmi_d_r;
  reg [NPINS-1:0] pins_d_r;
  reg [13:0] div_cnt_r;
  reg [7:0] tick_cnt_r;
  reg [2:0] pend_cause_r;
  reg por_seen_r;

  wire apb_wr = I_PSEL & I_PENABLE & I_PWRITE;
  wire apb_rd = I_PSEL & I_PENABLE & ~I_PWRITE;
  wire addr_ok = (I_PADDR == `LPMS_OFS_STANDBY_SELECT_CTRL) | (I_PADDR == `LPMS_OFS_SETTLE) |
                 (I_PADDR == `LPMS_OFS_DEEP_FLAGS) | (I_PADDR == `LPMS_OFS_EDGE_SEL) |
                 (I_PADDR == `LPMS_OFS_STATUS);

  // Edge detection on the wake pins, polarity from the edge select
  wire nmi_edge = nmi_edge_r ? (I_NMI_PIN & ~nmi_d_r) : (~I_NMI_PIN & nmi_d_r);
  reg [NPINS-1:0] pin_edge;
  reg [NPINS-1:0] pin_ok;
  integer k;
  always @*
  begin
    pin_edge = {NPINS{1'b0}};
    pin_ok = {NPINS{1'b0}};
    for (k = 0; k < NPINS; k = k + 1)
    begin
      // Sense 01 falling, 10 rising, 11 both, 00 level (no wake edge)
      pin_edge[k] = (pin_sense_r[2*k] & ~I_IRQ_PINS[k] & pins_d_r[k]) |
                    (pin_sense_r[2*k+1] & I_IRQ_PINS[k] & ~pins_d_r[k]);
      pin_ok[k] = pin_edge[k] & (I_PIN_PRIO[4*k +: 4] > I_CPU_MASK_LEVEL);
    end
  end
  wire any_pin = |pin_ok;
  wire deep_pin = |(pin_edge & DEEP_PIN_MASK[NPINS-1:0]);
  wire por_low = ~I_POR_N;
  wire manual_reset_pin_low = ~I_MANUAL_RESET_PIN_N;

  // Divider select to prescale terminal count, 1 up to 1/16384
  reg [13:0] div_top;
  reg [2:0] sel_now;
  always @*
  begin
    sel_now = (state_r == `LPMS_ST_DEEP_SETTLE) ? deep_settle_sel_r : settle_sel_r;
    case (sel_now)
      3'h0: div_top = `LPMS_DIV_TOP_0;
      3'h1: div_top = `LPMS_DIV_TOP_1;
      3'h2: div_top = `LPMS_DIV_TOP_2;
      3'h3: div_top = `LPMS_DIV_TOP_3;
      3'h4: div_top = `LPMS_DIV_TOP_4;
      3'h5: div_top = `LPMS_DIV_TOP_5;
      3'h6: div_top = `LPMS_DIV_TOP_6;
      default: div_top = `LPMS_DIV_TOP_7;
    endcase
  end
  wire settling = (state_r == `LPMS_ST_STANDBY_SELECT_SETTLE) | (state_r == `LPMS_ST_DEEP_SETTLE);
  wire div_tick = (div_cnt_r == div_top);
  wire overflow = settling & div_tick & (tick_cnt_r == `LPMS_SETTLE_TICKS - 8'h01);

  // Next state of the sequencer
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      `LPMS_ST_RUN:
      begin
        if (I_SLEEP_RETIRE)
        begin
          if (!standby_r)
            state_nxt = `LPMS_ST_SLEEP;
          else if (deep_r)
            state_nxt = `LPMS_ST_DEEP;
          else
            state_nxt = `LPMS_ST_STANDBY_SELECT;
        end
      end
      `LPMS_ST_SLEEP:
      begin
        if (por_low | manual_reset_pin_low)
          state_nxt = `LPMS_ST_RESET_HOLD;
        else if (I_IRQ_ACCEPT | I_BUS_ERROR)
          state_nxt = `LPMS_ST_RUN;
      end
      `LPMS_ST_STANDBY_SELECT:
      begin
        if (por_low | manual_reset_pin_low)
          state_nxt = `LPMS_ST_RESET_HOLD;
        else if (nmi_edge | any_pin)
          state_nxt = `LPMS_ST_STANDBY_SELECT_SETTLE;
      end
      `LPMS_ST_DEEP:
      begin
        if (por_low | manual_reset_pin_low)
          state_nxt = `LPMS_ST_RESET_HOLD;
        else if (nmi_edge | deep_pin)
          state_nxt = `LPMS_ST_DEEP_SETTLE;
      end
      `LPMS_ST_STANDBY_SELECT_SETTLE, `LPMS_ST_DEEP_SETTLE:
      begin
        if (por_low | manual_reset_pin_low)
          state_nxt = `LPMS_ST_RESET_HOLD;
        else if (overflow)
          state_nxt = `LPMS_ST_RUN;
      end
      `LPMS_ST_RESET_HOLD:
      begin
        // Exception processing starts once the pins return high
        if (!por_low && !manual_reset_pin_low)
          state_nxt = `LPMS_ST_RUN;
      end
      default: state_nxt = `LPMS_ST_RUN;
    endcase
  end

  // Exit cause for the leaving transition
  reg [2:0] cause_nxt;
  always @*
  begin
    cause_nxt = `LPMS_EXIT_NONE;
    if (state_r == `LPMS_ST_SLEEP && state_nxt == `LPMS_ST_RUN)
      cause_nxt = I_BUS_ERROR ? `LPMS_EXIT_BUSERR : `LPMS_EXIT_IRQ;
    else if (state_r == `LPMS_ST_STANDBY_SELECT_SETTLE && state_nxt == `LPMS_ST_RUN)
      cause_nxt = pend_cause_r;
    else if (state_r == `LPMS_ST_DEEP_SETTLE && state_nxt == `LPMS_ST_RUN)
      cause_nxt = `LPMS_EXIT_POR;
    else if (state_r == `LPMS_ST_RESET_HOLD && state_nxt == `LPMS_ST_RUN)
      cause_nxt = por_seen_r ? `LPMS_EXIT_POR : `LPMS_EXIT_MANUAL_RESET_PIN;
  end

  // Sequencer, counters and wake bookkeeping
  always @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      state_r <= `LPMS_ST_RUN;
      // Track the pins during reset so no false edge follows it
      nmi_d_r <= I_NMI_PIN;
      pins_d_r <= I_IRQ_PINS;
      div_cnt_r <= 14'h0000;
      tick_cnt_r <= 8'h00;
      pend_cause_r <= `LPMS_EXIT_NONE;
      por_seen_r <= 1'b0;
      O_EXIT_CAUSE <= `LPMS_EXIT_NONE;
      O_EXIT_PULSE <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      nmi_d_r <= I_NMI_PIN;
      pins_d_r <= I_IRQ_PINS;
      O_EXIT_CAUSE <= cause_nxt;
      O_EXIT_PULSE <= (cause_nxt != `LPMS_EXIT_NONE);
      if (state_nxt == `LPMS_ST_RESET_HOLD && state_r != `LPMS_ST_RESET_HOLD)
        por_seen_r <= por_low;
      else if (state_r == `LPMS_ST_RESET_HOLD && por_low)
        por_seen_r <= 1'b1;
      if (state_r == `LPMS_ST_STANDBY_SELECT && state_nxt == `LPMS_ST_STANDBY_SELECT_SETTLE)
        pend_cause_r <= nmi_edge ? `LPMS_EXIT_NMI : `LPMS_EXIT_PIN;
      if (!settling || overflow)
      begin
        div_cnt_r <= 14'h0000;
        tick_cnt_r <= 8'h00;
      end
      else if (div_tick)
      begin
        div_cnt_r <= 14'h0000;
        tick_cnt_r <= tick_cnt_r + 8'h01;
      end
      else
        div_cnt_r <= div_cnt_r + 14'h0001;
    end
  end

  // APB registers; deep flags clear by zero only after reading one
  wire wr_ctrl = apb_wr & (I_PADDR == `LPMS_OFS_STANDBY_SELECT_CTRL);
  wire wr_flags = apb_wr & (I_PADDR == `LPMS_OFS_DEEP_FLAGS);
  wire rd_flags = apb_rd & (I_PADDR == `LPMS_OFS_DEEP_FLAGS);
  wire deep_wake = (state_r == `LPMS_ST_DEEP) & (state_nxt != `LPMS_ST_DEEP);
  reg [15:0] flag_set;
  always @*
  begin
    flag_set = 16'h0000;
    flag_set[`LPMS_BIT_PIN_HOLD] = (state_r == `LPMS_ST_RUN) & (state_nxt == `LPMS_ST_DEEP);
    flag_set[`LPMS_BIT_MANUAL_RESET_PIN_FLAG] = deep_wake & manual_reset_pin_low;
    flag_set[`LPMS_BIT_NMI_FLAG] = deep_wake & nmi_edge & ~manual_reset_pin_low;
    flag_set[NPINS-1:0] = (deep_wake & ~manual_reset_pin_low) ? (pin_edge & DEEP_PIN_MASK[NPINS-1:0]) : {NPINS{1'b0}};
  end
  wire [15:0] flag_clr = wr_flags ? (flags_seen_r & ~I_PWDATA[15:0]) : 16'h0000;

  always @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      standby_r <= 1'b0;
      deep_r <= 1'b0;
      clk_mode_r <= 2'h0;
      settle_sel_r <= `LPMS_RST_SETTLE;
      deep_settle_sel_r <= `LPMS_RST_SETTLE;
      pin_sense_r <= {NPINS*2{1'b0}};
      nmi_edge_r <= 1'b0;
      flags_r <= `LPMS_RST_FLAGS;
      flags_seen_r <= `LPMS_RST_FLAGS;
      O_PRDATA <= 32'h00000000;
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
    end
    else
    begin
      // Ready one cycle into the access phase; writes land at the completing edge
      O_PREADY <= I_PSEL & I_PENABLE & ~O_PREADY;
      O_PSLVERR <= I_PSEL & I_PENABLE & ~O_PREADY & ~addr_ok;
      if (wr_ctrl && O_PREADY)
      begin
        standby_r <= I_PWDATA[`LPMS_BIT_STANDBY];
        deep_r <= I_PWDATA[`LPMS_BIT_DEEP];
        clk_mode_r <= I_PWDATA[`LPMS_CLKMODE_HI:`LPMS_CLKMODE_LO];
      end
      if (apb_wr && O_PREADY && I_PADDR == `LPMS_OFS_SETTLE)
      begin
        settle_sel_r <= I_PWDATA[`LPMS_SETTLE_SEL_HI:`LPMS_SETTLE_SEL_LO];
        deep_settle_sel_r <= I_PWDATA[`LPMS_DEEP_SEL_HI:`LPMS_DEEP_SEL_LO];
      end
      if (apb_wr && O_PREADY && I_PADDR == `LPMS_OFS_EDGE_SEL)
      begin
        pin_sense_r <= I_PWDATA[NPINS*2-1:0];
        nmi_edge_r <= I_PWDATA[`LPMS_BIT_NMI_EDGE];
      end
      flags_r <= (flags_r & ~(O_PREADY ? flag_clr : 16'h0000)) | flag_set;
      if (rd_flags && !O_PREADY)
        flags_seen_r <= flags_r;
      else if (wr_flags && O_PREADY)
        flags_seen_r <= 16'h0000;
      O_PRDATA <= 32'h00000000;
      if (apb_rd && !O_PREADY)
        case (I_PADDR)
          `LPMS_OFS_STANDBY_SELECT_CTRL: O_PRDATA <= {24'h000000, standby_r, deep_r, 4'h0, clk_mode_r};
          `LPMS_OFS_SETTLE: O_PRDATA <= {25'h0000000, deep_settle_sel_r, 1'b0, settle_sel_r};
          `LPMS_OFS_DEEP_FLAGS: O_PRDATA <= {16'h0000, flags_r};
          `LPMS_OFS_EDGE_SEL: O_PRDATA <= {15'h0000, nmi_edge_r, pin_sense_r};
          `LPMS_OFS_STATUS: O_PRDATA <= {29'h00000000, state_r};
          default: O_PRDATA <= 32'h00000000;
        endcase
    end
  end

  // Registered chip controls; clock modes 0 and 2 stop the external clock
  wire ext_stop_mode = (clk_mode_r == 2'h0) | (clk_mode_r == 2'h2);
  always @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      O_CPU_HALT <= 1'b0;
      O_CHIP_CLK_EN <= 1'b1;
      O_EXT_CLK_EN <= 1'b1;
      O_PERIPH_INIT <= 1'b0;
      O_POWER_OFF <= 1'b0;
      O_PIN_HOLD <= 1'b0;
      O_DMA_ABORT <= 1'b0;
      O_POR_HOLD <= 1'b0;
      O_MANUAL_RESET_PIN_HOLD <= 1'b0;
    end
    else
    begin
      O_CPU_HALT <= (state_nxt != `LPMS_ST_RUN);
      // chip clock only while running or sleeping
      O_CHIP_CLK_EN <= (state_nxt == `LPMS_ST_RUN) | (state_nxt == `LPMS_ST_SLEEP);
      O_EXT_CLK_EN <= ~(((state_nxt == `LPMS_ST_STANDBY_SELECT) | (state_nxt == `LPMS_ST_STANDBY_SELECT_SETTLE)) & ext_stop_mode) &
                      (state_nxt != `LPMS_ST_DEEP) & (state_nxt != `LPMS_ST_DEEP_SETTLE);
      O_PERIPH_INIT <= (state_r == `LPMS_ST_RUN) & (state_nxt == `LPMS_ST_STANDBY_SELECT);
      O_POWER_OFF <= (state_nxt == `LPMS_ST_DEEP) | (state_nxt == `LPMS_ST_DEEP_SETTLE);
      O_PIN_HOLD <= flags_r[`LPMS_BIT_PIN_HOLD];
      O_DMA_ABORT <= (state_r == `LPMS_ST_RUN) & I_SLEEP_RETIRE & standby_r;
      O_POR_HOLD <= (state_nxt == `LPMS_ST_RESET_HOLD) & por_low;
      O_MANUAL_RESET_PIN_HOLD <= (state_nxt == `LPMS_ST_RESET_HOLD) & manual_reset_pin_low & ~por_low;
    end
  end

endmodule

/* inc/lpms_defs.vh */
/*
  Constants for the low power mode sequencer: register offsets, field
  positions, reset values, states and settling counts.
  Assumes inclusion by bare name from the design, checker and bench files.
*/
`ifndef LPMS_DEFS_VH
`define LPMS_DEFS_VH

// Register byte offsets on the APB slave
`define LPMS_OFS_STANDBY_SELECT_CTRL 12'h000
`define LPMS_OFS_SETTLE 12'h004
`define LPMS_OFS_DEEP_FLAGS 12'h008
`define LPMS_OFS_EDGE_SEL 12'h00C
`define LPMS_OFS_STATUS 12'h010

// Standby control fields
`define LPMS_BIT_STANDBY 7
`define LPMS_BIT_DEEP 6
`define LPMS_CLKMODE_HI 1
`define LPMS_CLKMODE_LO 0

// Deep wake flag fields
`define LPMS_BIT_PIN_HOLD 15
`define LPMS_BIT_MANUAL_RESET_PIN_FLAG 9
`define LPMS_BIT_NMI_FLAG 8

// Edge select fields: nmi at 16, pin sense pairs in 15:0
`define LPMS_BIT_NMI_EDGE 16

// Reset values
`define LPMS_RST_SETTLE 3'h0
`define LPMS_RST_FLAGS 16'h0000

// Settling count multiplier
`define LPMS_SETTLE_TICKS 8'hFF

// Settle select fields and prescaler terminal counts (ratio minus one)
`define LPMS_SETTLE_SEL_HI 2
`define LPMS_SETTLE_SEL_LO 0
`define LPMS_DEEP_SEL_HI 6
`define LPMS_DEEP_SEL_LO 4
`define LPMS_DIV_TOP_0 14'h0000
`define LPMS_DIV_TOP_1 14'h003F
`define LPMS_DIV_TOP_2 14'h007F
`define LPMS_DIV_TOP_3 14'h00FF
`define LPMS_DIV_TOP_4 14'h01FF
`define LPMS_DIV_TOP_5 14'h03FF
`define LPMS_DIV_TOP_6 14'h0FFF
`define LPMS_DIV_TOP_7 14'h3FFF

// Sequencer states
`define LPMS_ST_RUN 3'h0
`define LPMS_ST_SLEEP 3'h1
`define LPMS_ST_STANDBY_SELECT 3'h2
`define LPMS_ST_STANDBY_SELECT_SETTLE 3'h3
`define LPMS_ST_DEEP 3'h4
`define LPMS_ST_DEEP_SETTLE 3'h5
`define LPMS_ST_RESET_HOLD 3'h6

// Exit causes reported to the core
`define LPMS_EXIT_NONE 3'h0
`define LPMS_EXIT_IRQ 3'h1
`define LPMS_EXIT_BUSERR 3'h2
`define LPMS_EXIT_NMI 3'h3
`define LPMS_EXIT_PIN 3'h4
`define LPMS_EXIT_POR 3'h5
`define LPMS_EXIT_MANUAL_RESET_PIN 3'h6

`endif

/* verif/lpms_seq_sva.sv */
/* Checker for the low power mode sequencer ports.
   Assumes one clock domain and the exit codes of lpms_defs.vh. */
`timescale 1ns/100ps
`include "lpms_defs.vh"
module lpms_seq_sva (
  // Clock and reset
  input wire I_REF_CLK,
  input wire I_RST,
  // Core side and reset pins
  input wire I_IRQ_ACCEPT,
  input wire I_BUS_ERROR,
  input wire I_SLEEP_RETIRE,
  input wire I_POR_N,
  input wire I_MANUAL_RESET_PIN_N,
  // Sequencer outputs
  input wire O_CPU_HALT,
  input wire O_CHIP_CLK_EN,
  input wire O_EXT_CLK_EN,
  input wire O_POWER_OFF,
  input wire O_PIN_HOLD,
  input wire O_POR_HOLD,
  input wire O_MANUAL_RESET_PIN_HOLD,
  input wire [2:0] O_EXIT_CAUSE,
  input wire O_EXIT_PULSE
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  // Light sleep: halted, clock still running, no reset pin in play
  wire asleep = O_CPU_HALT && O_CHIP_CLK_EN && !O_POR_HOLD && !O_MANUAL_RESET_PIN_HOLD && I_POR_N && I_MANUAL_RESET_PIN_N;
  a_sleep_halt: assert property (I_SLEEP_RETIRE && !O_CPU_HALT && I_POR_N && I_MANUAL_RESET_PIN_N |=> O_CPU_HALT)
    else $error("core not halted after sleep");
  a_sleep_ext: assert property (asleep |-> O_EXT_CLK_EN)
    else $error("external clock stopped in light sleep");
  a_irq_wake: assert property (asleep && I_IRQ_ACCEPT && !I_BUS_ERROR |=>
    O_EXIT_PULSE && !O_CPU_HALT && O_EXIT_CAUSE == `LPMS_EXIT_IRQ)
    else $error("accepted interrupt did not end sleep");
  a_buserr_wake: assert property (asleep && I_BUS_ERROR && !I_IRQ_ACCEPT |=>
    O_EXIT_PULSE && O_EXIT_CAUSE == `LPMS_EXIT_BUSERR)
    else $error("bus error did not end sleep");
  a_clk_off: assert property (!O_CHIP_CLK_EN |-> O_CPU_HALT)
    else $error("chip clock off while running");
  a_deep_hold: assert property ($rose(O_POWER_OFF) |-> ##[0:2] O_PIN_HOLD)
    else $error("pin hold not set on deep entry");
  a_deep_cause: assert property (O_EXIT_PULSE && $past(O_POWER_OFF) |-> O_EXIT_CAUSE == `LPMS_EXIT_POR)
    else $error("deep exit not a power-on reset");
  a_wake_clk: assert property (O_EXIT_PULSE |-> O_CHIP_CLK_EN && !O_POWER_OFF)
    else $error("exit reported with clock still off");
  c_pin_exit: cover property (O_EXIT_PULSE && O_EXIT_CAUSE == `LPMS_EXIT_PIN);
  c_por_hold: cover property (O_POR_HOLD);
  c_deep: cover property ($rose(O_POWER_OFF));
endmodule
bind lpms_sequencer lpms_seq_sva u_sva (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_IRQ_ACCEPT(I_IRQ_ACCEPT),
  .I_BUS_ERROR(I_BUS_ERROR), .I_SLEEP_RETIRE(I_SLEEP_RETIRE), .I_POR_N(I_POR_N), .I_MANUAL_RESET_PIN_N(I_MANUAL_RESET_PIN_N),
  .O_CPU_HALT(O_CPU_HALT), .O_CHIP_CLK_EN(O_CHIP_CLK_EN), .O_EXT_CLK_EN(O_EXT_CLK_EN), .O_POWER_OFF(O_POWER_OFF),
  .O_PIN_HOLD(O_PIN_HOLD), .O_POR_HOLD(O_POR_HOLD), .O_MANUAL_RESET_PIN_HOLD(O_MANUAL_RESET_PIN_HOLD), .O_EXIT_CAUSE(O_EXIT_CAUSE),
  .O_EXIT_PULSE(O_EXIT_PULSE));

/* verif/lpms_core_model.sv */
/* Core and interrupt controller partner: retires sleep, then wakes.
   Assumes a one-cycle go pulse from the bench per round. */
`timescale 1ns/100ps
module lpms_core_model (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Bench commands
  input wire i_go,
  input wire i_kind,
  input wire [7:0] i_wait,
  input wire [3:0] i_prio,
  input wire [3:0] i_mask,
  // Sequencer side
  input wire i_halt,
  output reg o_retire,
  output reg o_accept,
  output reg o_buserr
);
  reg [1:0] st_r;
  reg [7:0] cnt_r;
  // Retire, wait for the halt, then wake after a chosen delay
  always @(posedge i_clk)
  begin
    o_retire <= 1'b0;
    o_accept <= 1'b0;
    o_buserr <= 1'b0;
    if (i_rst)
      st_r <= 2'h0;
    else if (st_r == 2'h0 && i_go)
    begin
      o_retire <= 1'b1;
      cnt_r <= i_wait;
      st_r <= 2'h1;
    end
    else if (st_r == 2'h1 && i_halt)
      st_r <= 2'h2;
    else if (st_r == 2'h2 && cnt_r != 8'h00)
      cnt_r <= cnt_r - 8'h01;
    else if (st_r == 2'h2)
    begin
      o_accept <= !i_kind && (i_prio > i_mask);
      o_buserr <= i_kind;
      st_r <= 2'h0;
    end
  end
endmodule

/* verif/lpms_sequencer_tb.sv */
/* Self-checking bench for the low power mode sequencer.
   Assumes the core model and an APB master task drive the design. */
`timescale 1ns/100ps
`include "lpms_defs.vh"
module lpms_sequencer_tb;
  // Bench drive and observation
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prio = 32'h00000000, rd;
  logic [3:0] mask = 4'h0, rprio = 4'h0, m;
  logic nmi = 1'b0, por_n = 1'b1, manual_reset_pin_n = 1'b1, go = 1'b0, kind = 1'b0, slv;
  logic [7:0] pins = 8'hFF, wt = 8'h05;
  wire [31:0] prdata;
  wire [2:0] cause;
  wire retire, accept, buserr, pready, pslverr, halt, chip_clk, ext_clk, pinit, poff, phold, dabort, porh, mresh, xpulse;
  int err_count = 0, comparisons = 0, n, i, n_init = 0, n_abort = 0;
  lpms_sequencer DUT (.I_REF_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_SLEEP_RETIRE(retire), .I_IRQ_ACCEPT(accept), .I_BUS_ERROR(buserr), .I_CPU_MASK_LEVEL(mask),
    .I_PIN_PRIO(prio), .I_NMI_PIN(nmi), .I_IRQ_PINS(pins), .I_POR_N(por_n), .I_MANUAL_RESET_PIN_N(manual_reset_pin_n),
    .O_CPU_HALT(halt), .O_CHIP_CLK_EN(chip_clk), .O_EXT_CLK_EN(ext_clk), .O_PERIPH_INIT(pinit),
    .O_POWER_OFF(poff), .O_PIN_HOLD(phold), .O_DMA_ABORT(dabort), .O_POR_HOLD(porh), .O_MANUAL_RESET_PIN_HOLD(mresh),
    .O_EXIT_CAUSE(cause), .O_EXIT_PULSE(xpulse));
  lpms_core_model u_core (.i_clk(clk), .i_rst(rst), .i_go(go), .i_kind(kind), .i_wait(wt), .i_prio(rprio),
    .i_mask(mask), .i_halt(halt), .o_retire(retire), .o_accept(accept), .o_buserr(buserr));
  // 50 MHz clock
  always #10 clk = ~clk;
  // Count entry pulses so a doubled or missing one shows
  always @(posedge clk)
  begin
    if (pinit === 1'b1)
      n_init++;
    if (dabort === 1'b1)
      n_abort++;
  end
  // Compare one value and count it
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask
  // Settling cycles: prescaler ratio times 255
  function automatic int settle_len(input int sel);
    return ((sel == 0) ? 1 : (sel < 6) ? (32 << sel) : (sel == 6) ? 4096 : 16384) * 255;
  endfunction
  // One APB transfer, request held until ready is sampled
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // No answer time assumed; only the watchdog ends a hang
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Pulse the core model for one sleep round
  task automatic kick();
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  // Program the control bits, read them back, then sleep
  task automatic enter(input logic [31:0] c);
    apb(1'b1, `LPMS_OFS_STANDBY_SELECT_CTRL, c);
    apb(1'b0, `LPMS_OFS_STANDBY_SELECT_CTRL, 32'h00000000); // read back first
    chk("ctrl back", rd & 32'h000000C3, c); // committed bits
    kick();
    repeat (3) @(posedge clk);
  endtask
  // Wait for the exit pulse, bounded, counting cycles
  task automatic wait_exit();
    n = 0;
    do @(posedge clk); while (xpulse !== 1'b1 && n++ < 4000);
    if (xpulse !== 1'b1)
      err_count++;
  endtask
  // Print counts and the verdict, then stop
  task automatic conclude();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog against a hang
  initial
  begin
    #(20 * 30000);
    err_count++;
    conclude();
  end
  // Main sequence
  initial
  begin
    void'($urandom(32'hC1F0DA35));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 12'h0F0, 32'h00000000);
    chk("unmapped", {31'h0, slv}, 32'h00000001);
    apb(1'b1, `LPMS_OFS_EDGE_SEL, 32'h00010101);
    // Light sleep rounds: one masked, one ended by a bus error
    for (i = 0; i < 6; i++)
    begin
      m = 4'($urandom_range(0, 14));
      mask <= m;
      kind <= (i == 3);
      wt <= 8'($urandom_range(5, 40));
      rprio <= (i == 2) ? m : 4'($urandom_range(m + 1, 15));
      enter(32'h00000000);
      chk("sleep", {30'h0, halt, ext_clk}, 32'h00000003); // halted, clock out
      if (i == 2)
      begin
        repeat (60) @(posedge clk);
        chk("masked", {31'h0, halt}, 32'h00000001); // still asleep
        rprio <= m + 4'h1;
        kick();
      end
      wait_exit();
      chk("sleep cause", {29'h0, cause}, (i == 3) ? `LPMS_EXIT_BUSERR : `LPMS_EXIT_IRQ); // wake kind
    end
    // Standby woken by a pin above the mask
    apb(1'b1, `LPMS_OFS_SETTLE, 32'h00000000); // settle select first
    mask <= 4'h5;
    prio <= 32'h00090002;
    rprio <= 4'h0;
    enter(32'h00000080);
    chk("standby_select", {29'h0, chip_clk, ext_clk, halt}, 32'h00000001); // clocks stopped
    chk("init", n_init, 1); // peripherals reset once
    chk("abort", n_abort, 1); // transfer dropped
    pins <= 8'hFE;
    repeat (600) @(posedge clk);
    chk("low prio", {31'h0, chip_clk}, 32'h00000000); // stays stopped
    pins <= 8'hEE; // high at entry, low at return
    wait_exit();
    chk("pin cause", {29'h0, cause}, `LPMS_EXIT_PIN); // pin wake
    chk("settle", {31'h0, n >= settle_len(0) && n <= settle_len(0) + 8}, 32'h00000001); // settle period
    pins <= 8'hFF;
    // Standby left through each reset pin
    for (i = 0; i < 2; i++)
    begin
      enter((i == 0) ? 32'h00000080 : 32'h00000081);
      chk("ext mode", {31'h0, ext_clk}, (i == 0) ? 32'h0 : 32'h1); // clock mode
      por_n <= (i != 0);
      manual_reset_pin_n <= (i == 0);
      repeat (300) @(posedge clk); // held until settled
      chk("hold", {30'h0, porh, mresh}, (i == 0) ? 32'h2 : 32'h1); // held state
      por_n <= 1'b1;
      manual_reset_pin_n <= 1'b1;
      wait_exit();
      chk("rst cause", {29'h0, cause}, (i == 0) ? `LPMS_EXIT_POR : `LPMS_EXIT_MANUAL_RESET_PIN); // exit
    end
    // Deep standby from cleared flags, woken by a rising nmi
    apb(1'b0, `LPMS_OFS_DEEP_FLAGS, 32'h00000000);
    apb(1'b1, `LPMS_OFS_DEEP_FLAGS, 32'h00000000);
    apb(1'b0, `LPMS_OFS_DEEP_FLAGS, 32'h00000000);
    chk("flags clr", rd, 32'h00000000); // cleared before sleep
    enter(32'h000000C0);
    chk("deep", {30'h0, poff, phold}, 32'h00000003); // off, pins held
    nmi <= 1'b1;
    wait_exit();
    chk("deep cause", {29'h0, cause}, `LPMS_EXIT_POR); // reset exit
    chk("init all", n_init, 3); // standby entries only
    chk("abort all", n_abort, 4); // standby and deep entries
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, `LPMS_OFS_DEEP_FLAGS, 32'h00000000);
      apb(1'b0, `LPMS_OFS_DEEP_FLAGS, 32'h00000000);
      chk("flags", {rd[15:8], 7'h0, phold}, (i == 0) ? 32'h00008101 : 32'h0); // clear needs read
    end
    conclude();
  end
endmodule
